// [rtl/isp_slave.sv]
`include "isp_consts.svh"
`default_nettype none
module isp_slave
	import isp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	output logic irq
);
	localparam logic [2:0] FILT_LAST = 3'(`ISP_FILT_CYC - 1);
	localparam logic [11:0] FREE_LAST = 12'(`ISP_FREE_CYC - 1);

	logic [1:0] raw;
	logic [1:0] line;
	logic [1:0] prev_q;
	logic [7:0] tx_q;
	logic [7:0] rx_q;
	logic [6:0] adr_q;
	logic [8:0] ctl_q;
	logic [5:0] stat_q;
	logic bus_chg_q;
	logic [2:0] ien_q;
	logic rx_rdy_q;
	logic tx_emp_q;
	logic busy_q;
	logic sel_q;
	logic dir_q;
	logic nak_q;
	logic hold_q;
	logic [3:0] cnt_q;
	logic [7:0] shift_q;
	logic [11:0] free_q;
	isp_state_t state_q;
	logic [31:0] rd_data;
	logic hit;
	logic done;
	logic run;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic stall;
	logic adv;
	logic hold_d;
	logic addr_done;
	logic match;
	logic ev_load;
	logic ev_rx;
	logic ev_mism;
	logic ev_amatch;
	logic free_ev;
	logic wr_stat;
	logic wr_tx;

	assign raw = {scl_i, sda_i};

	// two flops per pin, then an optional stability filter
	for (genvar g = 0; g < 2; g++) begin : g_pin
		logic m_q;
		logic s_q;
		logic f_q;
		logic [2:0] c_q;
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				m_q <= 1'b1;
				s_q <= 1'b1;
			end else begin
				m_q <= raw[g];
				s_q <= m_q;
			end
		end
		// filter costs FILT_CYC cycles of latency on every edge
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				f_q <= 1'b1;
				c_q <= 3'h0;
			end else if (!ctl_q[`ISP_CTL_FILT]) begin
				f_q <= s_q;
				c_q <= 3'h0;
			end else if (s_q == f_q) begin
				c_q <= 3'h0;
			end else if (c_q == FILT_LAST) begin
				f_q <= s_q;
				c_q <= 3'h0;
			end else begin
				c_q <= c_q + 3'h1;
			end
		end
		assign line[g] = f_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= 2'h3;
		end else begin
			prev_q <= line;
		end
	end

	assign scl_rise = line[1] & !prev_q[1];
	assign scl_fall = !line[1] & prev_q[1];
	assign start_ev = line[1] & prev_q[1] & prev_q[0] & !line[0];
	assign stop_ev = line[1] & prev_q[1] & !prev_q[0] & line[0];
	assign run = ctl_q[`ISP_CTL_EN] & !ctl_q[`ISP_CTL_SRST];
	assign match = shift_q[7:1] == adr_q;
	assign addr_done = (state_q == ISP_ADDR) & (cnt_q == 4'h8) & scl_fall;

	// stretch only at byte boundaries, where tx data is missing or rx data is still unread
	always_comb begin
		stall = 1'b0;
		if (ctl_q[`ISP_CTL_STRETCH]) begin
			case (state_q)
				ISP_ACK_ADR: stall = dir_q & tx_emp_q;
				ISP_ACK_RX: stall = !nak_q & tx_emp_q;
				ISP_RX: stall = (cnt_q == 4'h8) & rx_rdy_q;
				default: stall = 1'b0;
			endcase
		end
	end

	assign adv = (scl_fall | hold_q) & !stall;
	assign hold_d = (scl_fall | hold_q) & stall & run;
	assign ev_load = adv & (((state_q == ISP_ACK_ADR) & dir_q) |
		((state_q == ISP_ACK_RX) & !nak_q));
	assign ev_rx = adv & (state_q == ISP_RX) & (cnt_q == 4'h8);
	assign ev_mism = scl_rise & (line[0] != sda_oe_n) &
		((state_q == ISP_TX) | (state_q == ISP_ACK_ADR) |
		(state_q == ISP_ACK_TX));
	assign ev_amatch = addr_done & match & ctl_q[`ISP_CTL_ASYNC] &
		!ctl_q[`ISP_CTL_ACTIVE];
	assign free_ev = ctl_q[`ISP_CTL_FREQ] & busy_q &
		(free_q == FREE_LAST);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_q <= 1'b0;
			scl_oe_n <= 1'b1;
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end else begin
			hold_q <= hold_d;
			scl_oe_n <= !(hold_d | hold_q);
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end
	end

	// bus-side sequencer; samples on SCL rise, drives after SCL fall
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ISP_IDLE;
			cnt_q <= 4'h0;
			shift_q <= 8'h00;
			sda_oe_n <= 1'b1;
			sel_q <= 1'b0;
			dir_q <= 1'b0;
			nak_q <= 1'b0;
		end else if (!run || stop_ev || free_ev) begin
			state_q <= ISP_IDLE;
			sda_oe_n <= 1'b1;
			sel_q <= 1'b0;
			cnt_q <= 4'h0;
		end else if (start_ev) begin
			state_q <= ISP_ADDR;
			sda_oe_n <= 1'b1;
			sel_q <= 1'b0;
			cnt_q <= 4'h0;
		end else begin
			case (state_q)
				ISP_ADDR, ISP_RX: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], line[0]};
						cnt_q <= cnt_q + 4'h1;
					end
					if (addr_done) begin
						if (match && ctl_q[`ISP_CTL_ACTIVE]) begin
							sel_q <= 1'b1;
							dir_q <= shift_q[0];
							sda_oe_n <= ctl_q[`ISP_CTL_NAK];
							state_q <= ctl_q[`ISP_CTL_NAK] ? ISP_WAIT : ISP_ACK_ADR;
						end else begin
							state_q <= ISP_WAIT;
						end
					end else if (ev_rx) begin
						sda_oe_n <= ctl_q[`ISP_CTL_NAK];
						state_q <= ISP_ACK_TX;
					end
				end
				ISP_ACK_ADR, ISP_ACK_RX: begin
					if (scl_rise && state_q == ISP_ACK_RX) begin
						nak_q <= line[0];
					end
					if (ev_load) begin
						shift_q <= ctl_q[`ISP_CTL_TXCLR] ? 8'h00 : tx_q;
						sda_oe_n <= ctl_q[`ISP_CTL_TXCLR] ? 1'b0 : tx_q[7];
						cnt_q <= 4'h0;
						state_q <= ISP_TX;
					end else if (adv) begin
						sda_oe_n <= 1'b1;
						cnt_q <= 4'h0;
						state_q <= state_q == ISP_ACK_ADR ? ISP_RX : ISP_WAIT;
					end
				end
				ISP_TX: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], 1'b0};
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall) begin
						if (cnt_q == 4'h8) begin
							sda_oe_n <= 1'b1;
							nak_q <= 1'b0;
							state_q <= ISP_ACK_RX;
						end else begin
							sda_oe_n <= shift_q[7];
						end
					end
				end
				ISP_ACK_TX: begin
					if (scl_fall) begin
						sda_oe_n <= 1'b1;
						cnt_q <= 4'h0;
						state_q <= ISP_RX;
					end
				end
				ISP_WAIT: begin
					sda_oe_n <= 1'b1;
				end
				default: begin
					sda_oe_n <= 1'b1;
				end
			endcase
		end
	end

	// bus busy and idle-line timer for the free request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			free_q <= 12'h000;
		end else begin
			if (start_ev) begin
				busy_q <= 1'b1;
			end else if (stop_ev || free_ev) begin
				busy_q <= 1'b0;
			end
			if (busy_q && line[1] && line[0] && !free_ev) begin
				free_q <= free_q + 12'h001;
			end else begin
				free_q <= 12'h000;
			end
		end
	end

	// apb slave: pready one cycle into the access phase
	assign hit = (paddr[31:18] == 14'h0000) & (paddr[1:0] == 2'b00) &
		((paddr[17:2] == `ISP_IDX_TX) | (paddr[17:2] == `ISP_IDX_RX) |
		(paddr[17:2] == `ISP_IDX_ADR) | (paddr[17:2] == `ISP_IDX_CTL) |
		(paddr[17:2] == `ISP_IDX_STAT) | (paddr[17:2] == `ISP_IDX_ASTAT) |
		(paddr[17:2] == `ISP_IDX_IEN));
	assign done = psel & penable & pready;
	assign wr_tx = done & pwrite & hit & (paddr[17:2] == `ISP_IDX_TX);
	assign wr_stat = done & pwrite & hit & (paddr[17:2] == `ISP_IDX_STAT);

	always_comb begin
		rd_data = 32'h0000_0000;
		case (paddr[17:2])
			`ISP_IDX_TX: rd_data[7:0] = tx_q;
			`ISP_IDX_RX: rd_data[7:0] = rx_q;
			`ISP_IDX_ADR: rd_data[6:0] = adr_q;
			`ISP_IDX_CTL: rd_data[8:0] = ctl_q;
			`ISP_IDX_STAT: rd_data[7:0] = {bus_chg_q, 1'b0, stat_q};
			`ISP_IDX_ASTAT: rd_data[4:0] = {rx_rdy_q, tx_emp_q, busy_q,
				sel_q, dir_q};
			`ISP_IDX_IEN: rd_data[2:0] = ien_q;
			default: rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & penable & !pready;
			pslverr <= psel & penable & !pready & !hit;
			if (psel && penable && !pready) begin
				prdata <= (hit && !pwrite) ? rd_data : 32'h0000_0000;
			end
		end
	end

	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_q <= `ISP_TX_RST;
			adr_q <= `ISP_ADR_RST;
			ctl_q <= `ISP_CTL_RSTV;
			ien_q <= `ISP_IEN_RSTV;
		end else begin
			if (ctl_q[`ISP_CTL_TXCLR]) begin
				tx_q <= 8'h00;
			end else if (wr_tx) begin
				tx_q <= pwdata[7:0];
			end
			if (done && pwrite && paddr[17:2] == `ISP_IDX_ADR && hit) begin
				adr_q <= pwdata[6:0];
			end
			if (done && pwrite && paddr[17:2] == `ISP_IDX_CTL && hit) begin
				ctl_q <= pwdata[8:0];
			end
			if (done && pwrite && paddr[17:2] == `ISP_IDX_IEN && hit) begin
				ien_q <= pwdata[2:0];
			end
		end
	end

	// receive data and access status; a new rx byte wins over a read clear, a tx write wins over a load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_q <= `ISP_RX_RST;
			rx_rdy_q <= 1'b0;
			tx_emp_q <= 1'b0;
		end else begin
			if (ev_rx) begin
				rx_q <= shift_q;
				rx_rdy_q <= 1'b1;
			end else if (done && !pwrite && hit &&
				paddr[17:2] == `ISP_IDX_RX) begin
				rx_rdy_q <= 1'b0;
			end
			if (wr_tx) begin
				tx_emp_q <= 1'b0;
			end else if (ev_load) begin
				tx_emp_q <= 1'b1;
			end
		end
	end

	// event flags: write one clears, bus change clears on a status read; a same-cycle event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= `ISP_STAT_RSTV;
			bus_chg_q <= 1'b0;
		end else begin
			if (start_ev || stop_ev || free_ev) begin
				bus_chg_q <= 1'b1;
			end else if (done && !pwrite && hit &&
				paddr[17:2] == `ISP_IDX_STAT) begin
				bus_chg_q <= 1'b0;
			end
			stat_q[`ISP_ST_UO] <= (ev_load & tx_emp_q) |
				(ev_rx & rx_rdy_q) |
				(stat_q[`ISP_ST_UO] & !(wr_stat & pwdata[`ISP_ST_UO]));
			stat_q[`ISP_ST_FREE] <= free_ev |
				(stat_q[`ISP_ST_FREE] & !(wr_stat & pwdata[`ISP_ST_FREE]));
			stat_q[`ISP_ST_MISM] <= ev_mism |
				(stat_q[`ISP_ST_MISM] & !(wr_stat & pwdata[`ISP_ST_MISM]));
			stat_q[`ISP_ST_AMATCH] <= ev_amatch |
				(stat_q[`ISP_ST_AMATCH] &
				!(wr_stat & pwdata[`ISP_ST_AMATCH]));
			if (scl_rise && state_q == ISP_ACK_RX) begin
				stat_q[`ISP_ST_REFUSED] <= line[0];
			end else if (wr_stat && pwdata[`ISP_ST_REFUSED]) begin
				stat_q[`ISP_ST_REFUSED] <= 1'b0;
			end
			stat_q[`ISP_ST_STOP] <= stop_ev |
				(stat_q[`ISP_ST_STOP] & !(wr_stat & pwdata[`ISP_ST_STOP]));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= (ien_q[2] & bus_chg_q) | (ien_q[1] & rx_rdy_q) |
				(ien_q[0] & tx_emp_q);
		end
	end
endmodule : isp_slave
`default_nettype wire

// [rtl/isp_consts.svh]
`ifndef ISP_CONSTS_SVH
`define ISP_CONSTS_SVH
`define ISP_IDX_TX 16'h4360
`define ISP_IDX_RX 16'h4362
`define ISP_IDX_ADR 16'h4364
`define ISP_IDX_CTL 16'h4366
`define ISP_IDX_STAT 16'h4368
`define ISP_IDX_ASTAT 16'h436a
`define ISP_IDX_IEN 16'h436c
`define ISP_CTL_TXCLR 8
`define ISP_CTL_EN 7
`define ISP_CTL_SRST 6
`define ISP_CTL_NAK 5
`define ISP_CTL_FREQ 4
`define ISP_CTL_STRETCH 3
`define ISP_CTL_FILT 2
`define ISP_CTL_ASYNC 1
`define ISP_CTL_ACTIVE 0
`define ISP_ST_BUSCHG 7
`define ISP_ST_UO 5
`define ISP_ST_FREE 4
`define ISP_ST_MISM 3
`define ISP_ST_AMATCH 2
`define ISP_ST_REFUSED 1
`define ISP_ST_STOP 0
`define ISP_AS_RX_READY_FLAG 4
`define ISP_AS_TX_EMPTY_FLAG 3
`define ISP_AS_BUSY 2
`define ISP_AS_SEL 1
`define ISP_AS_DIR 0
`define ISP_TX_RST 8'h00
`define ISP_RX_RST 8'h00
`define ISP_ADR_RST 7'h00
`define ISP_CTL_RSTV 9'h000
`define ISP_STAT_RSTV 6'h00
`define ISP_IEN_RSTV 3'h0
`define ISP_PCLK_NS 4
`define ISP_FILT_NS 16
`define ISP_FILT_CYC (`ISP_FILT_NS / `ISP_PCLK_NS)
`define ISP_FREE_NS 4000
`define ISP_FREE_CYC (`ISP_FREE_NS / `ISP_PCLK_NS)
`endif

// [rtl/isp_pkg.sv]
`default_nettype none
package isp_pkg;
	typedef enum logic [2:0] {
		ISP_IDLE = 3'b000,
		ISP_ADDR = 3'b001,
		ISP_ACK_ADR = 3'b010,
		ISP_TX = 3'b011,
		ISP_ACK_RX = 3'b100,
		ISP_RX = 3'b101,
		ISP_ACK_TX = 3'b110,
		ISP_WAIT = 3'b111
	} isp_state_t;
endpackage : isp_pkg
`default_nettype wire

// [testbench/isp_bus_master.sv]
`default_nettype none
module isp_bus_master(
	input wire logic scl_w,
	input wire logic sda_w,
	output logic scl_m,
	output logic sda_m,
	output logic stuck
);
	timeunit 1ns;
	timeprecision 1ps;
	// quarter of a 125 ns bus clock, free of the pclk phase
	localparam realtime Q = 31.25;
	initial begin
		scl_m = 1'b1;
		sda_m = 1'b1;
		stuck = 1'b0;
	end
	// waits out a stretch, but never for ever
	task automatic bit_t(input logic b, output logic s);
		int k;
		sda_m = b;
		#Q;
		scl_m = 1'b1;
		for (k = 0; k < 4000 && scl_w !== 1'b1; k++)
			#1;
		if (k == 4000)
			stuck = 1'b1;
		#Q;
		s = sda_w;
		#Q;
		scl_m = 1'b0;
		#Q;
	endtask : bit_t
	task automatic start;
		sda_m = 1'b1;
		scl_m = 1'b1;
		#Q;
		sda_m = 1'b0;
		#Q;
		scl_m = 1'b0;
		#Q;
	endtask : start
	task automatic stop;
		sda_m = 1'b0;
		#Q;
		scl_m = 1'b1;
		#Q;
		sda_m = 1'b1;
		#(4 * Q);
	endtask : stop
	task automatic tx(input logic [7:0] d, output logic a);
		logic x;
		for (int i = 7; i >= 0; i--)
			bit_t(d[i], x);
		bit_t(1'b1, a);
	endtask : tx
	task automatic rx(output logic [7:0] d, input logic n);
		logic x;
		for (int i = 7; i >= 0; i--)
			bit_t(1'b1, d[i]);
		bit_t(n, x);
	endtask : rx
endmodule : isp_bus_master
`default_nettype wire

// [testbench/isp_slave_props.sv]
`include "isp_consts.svh"
`default_nettype none
module isp_slave_props(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl_oe_n,
	input wire logic sda_oe_n,
	input wire logic irq
);
	logic [8:0] ctl_q;
	logic [8:0] ctl_p_q;
	logic [8:0] ctl_pp_q;
	logic [2:0] ien_q;
	wire logic wdone;
	wire logic [8:0] on_w;
	wire logic [8:0] off_w;
	assign wdone = psel & penable & pready & pwrite & ~pslverr;
	// outputs are registered, so a setting counts once it stood three cycles
	assign on_w = ctl_q & ctl_p_q & ctl_pp_q;
	assign off_w = ~(ctl_q | ctl_p_q | ctl_pp_q);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= 9'h000;
			ctl_p_q <= 9'h000;
			ctl_pp_q <= 9'h000;
			ien_q <= 3'h0;
		end else begin
			ctl_p_q <= ctl_q;
			ctl_pp_q <= ctl_p_q;
			if (wdone && paddr == {14'h0, `ISP_IDX_CTL, 2'b00})
				ctl_q <= pwdata[8:0];
			if (wdone && paddr == {14'h0, `ISP_IDX_IEN, 2'b00})
				ien_q <= pwdata[2:0];
		end
	end
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_wait_one: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("apb answer not after one wait state");
	a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("refused access returned data");
	a_rsv_zero: assert property (pready && !pwrite |-> prdata[31:9] == 0)
		else $error("reserved read bits not zero");
	a_txclr_read: assert property (pready && !pwrite && on_w[8] &&
		paddr == {14'h0, `ISP_IDX_TX, 2'b00} |-> prdata == 32'h0)
		else $error("transmit byte not cleared");
	a_off_quiet: assert property (off_w[7] |-> sda_oe_n && scl_oe_n)
		else $error("disabled slave drives the bus");
	a_srst_quiet: assert property (on_w[6] |-> sda_oe_n && scl_oe_n)
		else $error("slave in soft reset drives the bus");
	a_nak_mode: assert property (on_w[5] |-> sda_oe_n)
		else $error("acknowledge driven in refuse mode");
	a_standby: assert property (off_w[0] |-> sda_oe_n)
		else $error("standby slave drives data");
	a_no_stretch: assert property (off_w[3] |-> scl_oe_n)
		else $error("clock held with stretching off");
	a_irq_mask: assert property (ien_q == 3'h0 && $past(ien_q) == 3'h0 |=> !irq)
		else $error("interrupt with all enables off");
	c_ack: cover property (!sda_oe_n);
	c_irq: cover property ($rose(irq));
	c_refused: cover property (pready && pslverr);
	c_stretch: cover property (!scl_oe_n);
endmodule : isp_slave_props
bind isp_slave isp_slave_props isp_slave_props_i(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .scl_oe_n(scl_oe_n),
	.sda_oe_n(sda_oe_n), .irq(irq));
`default_nettype wire

// [testbench/test_i2c_slave_port.sv]
`include "isp_consts.svh"
`default_nettype none
module test_i2c_slave_port;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic scl_o, scl_oe_n, sda_o, sda_oe_n, irq, scl_m, sda_m, stk, ack;
	logic [31:0] paddr, pwdata, prdata, r;
	logic [15:0] rnd = 16'h3b4a;
	logic [7:0] v, g;
	logic [6:0] a;
	int num_errors = 0;
	int n_compared = 0;
	wire logic scl_w;
	wire logic sda_w;
	logic [15:0] ix [7] = '{`ISP_IDX_TX, `ISP_IDX_RX, `ISP_IDX_ADR,
		`ISP_IDX_CTL, `ISP_IDX_STAT, `ISP_IDX_ASTAT, `ISP_IDX_IEN};
	logic [15:0] rw [4] = '{`ISP_IDX_TX, `ISP_IDX_ADR, `ISP_IDX_IEN,
		`ISP_IDX_RX};
	logic [31:0] mk [4] = '{32'hff, 32'h7f, 32'h7, 32'h0};
	logic [31:0] cv [5] = '{32'h81, 32'ha1, 32'h01, 32'h82, 32'hc1};
	// pull-ups win unless someone pulls low
	assign scl_w = scl_m & (scl_oe_n | scl_o);
	assign sda_w = sda_m & (sda_oe_n | sda_o);
	isp_slave isp_slave_i(.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_w),
		.scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_n(sda_oe_n), .irq(irq));
	isp_bus_master isp_bus_master_i(.scl_w(scl_w), .sda_w(sda_w),
		.scl_m(scl_m), .sda_m(sda_m), .stuck(stk));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nx
	function automatic logic [31:0] ba(input logic [15:0] i);
		return {14'h0, i, 2'b00};
	endfunction : ba
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [15:0] i,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ba(i);
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 64);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			num_errors++;
			test_done;
		end
	endtask : apb
	task automatic wr(input logic [15:0] i, input logic [31:0] d);
		apb(1'b1, i, d);
	endtask : wr
	task automatic rc(input logic [15:0] i, input logic [31:0] x);
		apb(1'b0, i, 32'h0);
		chk(r, x);
	endtask : rc
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 7; k++)
			rc(ix[k], 32'h0);
		apb(1'b0, 16'h4370, 32'h0);
		chk(32'(e), 32'h1);
		for (int j = 0; j < 4; j++) begin
			rnd = nx(rnd);
			wr(rw[j], {16'hffff, rnd});
			rc(rw[j], {16'h0, rnd} & mk[j]);
		end
		wr(`ISP_IDX_TX, 32'h5a);
		wr(`ISP_IDX_CTL, 32'h100);
		wr(`ISP_IDX_TX, 32'h33);
		rc(`ISP_IDX_TX, 32'h0);
		$display("test registers done");
		rnd = nx(rnd);
		a = rnd[14:8];
		v = rnd[7:0];
		wr(`ISP_IDX_ADR, 32'(a));
		wr(`ISP_IDX_IEN, 32'h2);
		wr(`ISP_IDX_CTL, 32'h81);
		isp_bus_master_i.start;
		isp_bus_master_i.tx({a, 1'b0}, ack);
		chk(32'(ack), 32'h0);
		isp_bus_master_i.tx(v, ack);
		chk(32'(ack), 32'h0);
		g = ~v;
		isp_bus_master_i.tx(g, ack);
		chk(32'(ack), 32'h0);
		isp_bus_master_i.stop;
		rc(`ISP_IDX_ASTAT, 32'h10);
		chk(32'(irq), 32'h1);
		rc(`ISP_IDX_RX, 32'(g));
		// irq is registered behind rx ready, so let two edges pass
		repeat (2) @(posedge pclk);
		chk(32'(irq), 32'h0);
		rc(`ISP_IDX_STAT, 32'ha1);
		wr(`ISP_IDX_STAT, 32'h0);
		rc(`ISP_IDX_STAT, 32'h21);
		wr(`ISP_IDX_STAT, 32'h21);
		rc(`ISP_IDX_STAT, 32'h0);
		wr(`ISP_IDX_IEN, 32'h0);
		$display("test write done");
		// wrong address, refuse mode, disabled, clockless standby, soft reset
		for (int k = 0; k < 5; k++) begin
			wr(`ISP_IDX_CTL, cv[k]);
			isp_bus_master_i.start;
			isp_bus_master_i.tx({(k == 0) ? a ^ 7'h01 : a, 1'b0}, ack);
			isp_bus_master_i.stop;
			chk(32'(ack), 32'h1);
		end
		$display("test refusal done");
		wr(`ISP_IDX_CTL, 32'h81);
		rc(`ISP_IDX_STAT, 32'h85);
		wr(`ISP_IDX_STAT, 32'h3f);
		rnd = nx(rnd);
		v = rnd[7:0];
		wr(`ISP_IDX_TX, 32'(v));
		isp_bus_master_i.start;
		isp_bus_master_i.tx({a, 1'b1}, ack);
		chk(32'(ack), 32'h0);
		isp_bus_master_i.rx(g, 1'b0);
		chk(32'(g), 32'(v));
		isp_bus_master_i.rx(g, 1'b1);
		isp_bus_master_i.stop;
		chk(32'(g), 32'(v));
		rc(`ISP_IDX_STAT, 32'ha3);
		chk(32'(stk), 32'h0);
		$display("test read done");
		// a full receive register makes the slave hold scl low
		wr(`ISP_IDX_CTL, 32'h89);
		g = ~v;
		isp_bus_master_i.start;
		isp_bus_master_i.tx({a, 1'b0}, ack);
		isp_bus_master_i.tx(v, ack);
		fork
			isp_bus_master_i.tx(g, ack);
			begin
				repeat (300) @(posedge pclk);
				chk(32'(scl_oe_n), 32'h0);
				rc(`ISP_IDX_RX, 32'(v));
			end
		join
		isp_bus_master_i.stop;
		chk(32'(ack), 32'h0);
		rc(`ISP_IDX_RX, 32'(g));
		chk(32'(stk), 32'h0);
		$display("test stretch done");
		test_done;
	end
endmodule : test_i2c_slave_port
`default_nettype wire
